// ===== rtl/sac_pkg.sv
/*
 Shared constants for the serial converter sequencer: frame timing,
 power-down thresholds, resolution choices and controller states.
 Assumes both ends compile it first.
*/
package sac_pkg;
   localparam int FRAME_EDGES      = 16;
   localparam int MIN_EDGES        = 17;
   localparam int FIRST_BIT_EDGE   = 3;
   localparam int LIGHT_PD_EDGES   = 2;
   localparam int DEEP_PD_EDGES    = 4;
   localparam int RES_HIGH         = 14;
   localparam int RES_LOW          = 12;
   localparam int WORD_W           = 16;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int SETTLE_MS        = 2;
   localparam int SETTLE_CYCLES    = SETTLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int ACQ_NS           = 39;
   localparam int ACQ_CYCLES       = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W            = 6;

   typedef enum logic [1:0]
   {
      SAC_ACTIVE = 2'h0,
      SAC_LIGHT  = 2'h1,
      SAC_DEEP   = 2'h2
   } sac_pwr_t;

   typedef enum logic [4:0]
   {
      SAC_IDLE  = 5'h01,
      SAC_START = 5'h02,
      SAC_SHIFT = 5'h04,
      SAC_GAP   = 5'h08,
      SAC_WAKE  = 5'h10
   } sac_ctl_t;
endpackage

// ===== rtl/sac_link_if.sv
/*
 Three-wire link between the converter and its controller.
 Assumes the controller makes the shift clock and the strobe.
*/
`timescale 1ns/10ps
interface sac_link_if;
   logic shift_clk;
   logic conversion_start_strobe;
   logic serial_result_output;
   logic serial_result_oe_n;
   logic result_line;

   assign result_line = serial_result_oe_n ? 1'b1 : serial_result_output;

   modport device
   (
      input  shift_clk,
      input  conversion_start_strobe,
      output serial_result_output,
      output serial_result_oe_n
   );
   modport ctrl
   (
      output shift_clk,
      output conversion_start_strobe,
      input  result_line,
      input  serial_result_oe_n
   );
endinterface

// ===== rtl/sac_buf2.sv
/*
 Two-entry valid/ready buffer for result words.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module sac_buf2
   import sac_pkg::*;
#(
   parameter int W = WORD_W
)
(
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_q [2];
   logic         wr_q;
   logic         rd_q;
   logic [1:0]   cnt_q;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;

   assign in_ready  = cnt_q != 2'h2;
   assign out_valid = cnt_q != 2'h0;
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_q[wr_q] <= in_data;
            wr_q        <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ===== rtl/sac_device.sv
/*
 Converter end: strobe and shift-clock sequencing, power-down, result shifter.
 Assumes link pins arrive asynchronously and the sample input is a digital word.
*/
// Function
// - Comes up active, ready to convert
// - Two strobes without clock: light power-down
// - Reference stays on in light power-down
// - Clock edge wakes light, convert next cycle
// - Four strobes without clock: deep power-down
// - Clock wakes deep; controller counts settle time to ref_settled but takes convert_req before then
// - Deep entries limited to every 2ms; the controller has no such limit and takes sleep_req at any time in idle
// - Strobes ignored until sixteen clock edges pass; the device stays busy until the seventeenth edge, but a second bare strobe ends the frame
// - Controller gives eighteen clocks between strobes
// - Controller adds one period for acquisition
// - Data stream ends within sixteen clocks
// - Strobe duty cycle free, usable as sync
// - Strobe half a shift-clock period (HALF_DIV core clocks) wide, delayed for sync
// - Results two's complement, selectable LSB weight
// - Result is difference of the inputs
// - Controller keeps shared bus quiet meanwhile
// - MSB first from third clock edge
// - Output high impedance except while sending
// - Controller captures on falling clock edge
// - Sample held; output is previous sample
`timescale 1ns/10ps
module sac_device
   import sac_pkg::*;
#(
   parameter int RES = RES_HIGH
)
(
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   sac_link_if.device                link,
   input  wire logic signed [RES-1:0] noninverting_analog_input,
   input  wire logic signed [RES-1:0] inverting_analog_input,
   output logic [1:0]                power_state,
   output logic                      reference_on
);
   logic [2:0]          clk_s_q;
   logic [2:0]          cnv_s_q;
   logic                clk_lvl_q;
   logic                cnv_lvl_q;
   logic                busy_q;
   logic [CNT_W-1:0]    edge_q;
   logic [2:0]          strobes_q;
   sac_pwr_t            pwr_q;
   logic signed [RES-1:0] held_q;
   logic [RES-1:0]      result_q;
   logic [WORD_W-1:0]   shreg_q;
   logic                sdo_q;
   logic                oe_n_q;

   // Three-stage synchronisers, change counts when stages two and three agree
   wire clk_agree = clk_s_q[1] == clk_s_q[2];
   wire cnv_agree = cnv_s_q[1] == cnv_s_q[2];
   wire clk_rise  = clk_agree && clk_s_q[2] && !clk_lvl_q;
   wire cnv_rise  = cnv_agree && cnv_s_q[2] && !cnv_lvl_q;
   wire start     = cnv_rise && !busy_q;
   wire signed [RES-1:0] diff = noninverting_analog_input - inverting_analog_input;
   wire last_edge = busy_q && clk_rise && edge_q == CNT_W'(FRAME_EDGES);
   // Second bare strobe abandons the frame that the first one opened
   wire pd_enter  = cnv_rise && !clk_rise && busy_q && strobes_q + 3'h1 >= 3'(LIGHT_PD_EDGES);
   wire in_bits   = edge_q >= CNT_W'(FIRST_BIT_EDGE - 1) && edge_q < CNT_W'(FIRST_BIT_EDGE - 1 + RES);

   assign link.serial_result_output = sdo_q;
   assign link.serial_result_oe_n   = oe_n_q;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         clk_s_q   <= 3'h0;
         cnv_s_q   <= 3'h0;
         clk_lvl_q <= 1'b0;
         cnv_lvl_q <= 1'b0;
      end
      else
      begin
         clk_s_q <= {clk_s_q[1:0], link.shift_clk};
         cnv_s_q <= {cnv_s_q[1:0], link.conversion_start_strobe};
         if (clk_agree)
            clk_lvl_q <= clk_s_q[2];
         if (cnv_agree)
            cnv_lvl_q <= cnv_s_q[2];
      end
   end

   // Power-down selection from strobes since last clock edge
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         strobes_q <= 3'h0;
         pwr_q     <= SAC_ACTIVE;
      end
      else if (clk_rise)
      begin
         strobes_q <= 3'h0;
         pwr_q     <= SAC_ACTIVE;
      end
      else if (cnv_rise)
      begin
         if (strobes_q != 3'h7)
            strobes_q <= strobes_q + 3'h1;
         if (strobes_q + 3'h1 >= 3'(DEEP_PD_EDGES))
            pwr_q <= SAC_DEEP;
         else if (strobes_q + 3'h1 >= 3'(LIGHT_PD_EDGES))
            pwr_q <= SAC_LIGHT;
      end
   end

   // Frame sequencer and result shifter
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy_q   <= 1'b0;
         edge_q   <= '0;
         held_q   <= '0;
         result_q <= '0;
         shreg_q  <= '0;
         sdo_q    <= 1'b0;
         oe_n_q   <= 1'b1;
      end
      else
      begin
         if (start)
         begin
            busy_q   <= 1'b1;
            edge_q   <= '0;
            held_q   <= diff;
            result_q <= held_q;
            shreg_q  <= {held_q, {(WORD_W-RES){1'b0}}};
         end
         else if (pd_enter)
         begin
            busy_q <= 1'b0;
            oe_n_q <= 1'b1;
         end
         else if (busy_q && clk_rise)
         begin
            edge_q <= edge_q + CNT_W'(1);
            if (in_bits)
            begin
               sdo_q   <= shreg_q[WORD_W-1];
               shreg_q <= {shreg_q[WORD_W-2:0], 1'b0};
               oe_n_q  <= 1'b0;
            end
            else
               oe_n_q <= 1'b1;
            if (last_edge)
               busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         power_state  <= SAC_ACTIVE;
         reference_on <= 1'b1;
      end
      else
      begin
         power_state  <= pwr_q;
         reference_on <= pwr_q != SAC_DEEP;
      end
   end
endmodule

// ===== rtl/sac_ctrl.sv
/*
 Controller end: makes shift clock and strobe, captures result words.
 Assumes the converter end sits on the same link interface.
*/
`timescale 1ns/10ps
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int RES       = RES_HIGH,
   parameter int SETTLE    = SETTLE_CYCLES,
   parameter int HALF_DIV  = 2
)
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   sac_link_if.ctrl               link,
   input  wire logic              convert_req,
   input  wire logic              nap_req,
   input  wire logic              sleep_req,
   output logic                   busy,
   output logic                   word_valid,
   input  wire logic              word_ready,
   output logic [WORD_W-1:0]      word_data,
   output logic                   ref_settled
);
   sac_ctl_t          st_q;
   logic [7:0]        div_q;
   logic              sck_q;
   logic              cnv_q;
   logic [CNT_W-1:0]  edge_q;
   logic [WORD_W-1:0] sh_q;
   logic              push_q;
   logic [WORD_W-1:0] pdata_q;
   logic [2:0]        pulses_q;
   logic              deep_q;
   logic [31:0]       settle_q;
   logic              in_ready;

   wire tick  = div_q == 8'(HALF_DIV - 1);
   wire rise  = tick && !sck_q;
   wire fall  = tick && sck_q;
   wire frame_edges = edge_q >= CNT_W'(MIN_EDGES + 1);

   assign link.shift_clk               = sck_q;
   assign link.conversion_start_strobe = cnv_q;

   sac_buf2 #(.W(WORD_W)) u_buf
   (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .in_valid  (push_q),
      .in_ready  (in_ready),
      .in_data   (pdata_q),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_data)
   );

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q     <= SAC_IDLE;
         div_q    <= '0;
         sck_q    <= 1'b0;
         cnv_q    <= 1'b0;
         edge_q   <= '0;
         sh_q     <= '0;
         push_q   <= 1'b0;
         pdata_q  <= '0;
         pulses_q <= '0;
         deep_q   <= 1'b0;
         settle_q <= '0;
         busy     <= 1'b0;
         ref_settled <= 1'b1;
      end
      else
      begin
         div_q  <= tick ? 8'h00 : div_q + 8'h01;
         push_q <= 1'b0;
         if (settle_q != 32'h0)
            settle_q <= settle_q - 32'h1;
         ref_settled <= settle_q == 32'h0 && !deep_q;
         unique case (st_q)
            SAC_IDLE:
            begin
               busy <= 1'b0;
               // Drop the clock left high by a wake edge
               if (tick && sck_q)
                  sck_q <= 1'b0;
               else if (tick && (nap_req || sleep_req))
               begin
                  cnv_q <= ~cnv_q;
                  if (cnv_q)
                     pulses_q <= pulses_q + 3'h1;
                  if (cnv_q && pulses_q + 3'h1 == 3'(sleep_req ? DEEP_PD_EDGES : LIGHT_PD_EDGES))
                  begin
                     deep_q <= sleep_req;
                     st_q   <= SAC_WAKE;
                  end
               end
               else if (convert_req && in_ready && tick && !sck_q)
               begin
                  cnv_q  <= 1'b1;
                  edge_q <= '0;
                  busy   <= 1'b1;
                  st_q   <= SAC_START;
               end
            end
            SAC_WAKE:
               if (!nap_req && !sleep_req && rise)
               begin
                  sck_q    <= 1'b1;
                  pulses_q <= '0;
                  if (deep_q)
                     settle_q <= 32'(SETTLE);
                  deep_q   <= 1'b0;
                  st_q     <= SAC_IDLE;
               end
            default:
            begin
               if (tick)
                  sck_q <= ~sck_q;
               if (rise)
               begin
                  edge_q <= edge_q + CNT_W'(1);
                  cnv_q  <= 1'b0;
               end
               // Bit from rise k is settled by the fall after rise k+1
               if (fall && edge_q >= CNT_W'(FIRST_BIT_EDGE + 1) && edge_q < CNT_W'(FIRST_BIT_EDGE + 1 + RES))
                  sh_q <= {sh_q[WORD_W-2:0], link.result_line};
               if (fall && edge_q == CNT_W'(FIRST_BIT_EDGE + 1 + RES))
               begin
                  push_q  <= 1'b1;
                  pdata_q <= WORD_W'(signed'(sh_q[RES-1:0]));
               end
               if (fall && frame_edges)
                  st_q <= SAC_IDLE;
               else if (edge_q != '0)
                  st_q <= SAC_SHIFT;
            end
         endcase
         if (!tick)
            div_q <= div_q + 8'h01;
      end
   end
endmodule

// ===== bench/sac_properties.sv
/*
 Link checker: timing of the result line and power states against strobe and shift-clock edges.
 Assumes plain link signals and device status, and one clock.
*/
`timescale 1ns/10ps
module sac_properties
   import sac_pkg::*;
#(
   parameter int RES = RES_HIGH
)
(
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       shift_clk,
   input wire logic       conversion_start_strobe,
   input wire logic       serial_result_output,
   input wire logic       serial_result_oe_n,
   input wire logic [1:0] power_state,
   input wire logic       reference_on
);
   logic       sck_q;
   logic       stb_q;
   logic [4:0] rise_q;
   logic [2:0] pend_q;
   wire        sck_rise = shift_clk & ~sck_q;
   wire        stb_rise = conversion_start_strobe & ~stb_q;

   // Clock rises since strobe, strobes since clock rise
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sck_q  <= 1'b0;
         stb_q  <= 1'b0;
         rise_q <= 5'h00;
         pend_q <= 3'h0;
      end
      else
      begin
         sck_q  <= shift_clk;
         stb_q  <= conversion_start_strobe;
         rise_q <= stb_rise ? 5'h00 : rise_q + {4'h0, sck_rise & (rise_q != 5'h1f)};
         pend_q <= sck_rise ? 3'h0 : pend_q + {2'h0, stb_rise & (pend_q != 3'h4)};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   AST_DRIVE_WINDOW: assert property (!serial_result_oe_n |-> rise_q inside {[3:RES+3]})
      else $error("result line driven outside its bit slots");
   AST_PD_QUIET: assert property (power_state != 2'h0 |-> serial_result_oe_n)
      else $error("result line driven while powered down");
   AST_NAP_REF: assert property (power_state == 2'h1 |-> reference_on)
      else $error("reference off in light power-down");
   AST_REF_OFF_DEEP: assert property (!reference_on |-> power_state == 2'h2)
      else $error("reference off outside deep power-down");
   AST_ACTIVE_AT_START: assert property ($rose(nrst) |-> power_state == 2'h0 && reference_on && serial_result_oe_n)
      else $error("not active and idle after reset");
   AST_NAP_ENTRY: assert property (stb_rise && pend_q == 3'h1 |-> ##[1:8] power_state != 2'h0)
      else $error("no power-down after second bare strobe");
   AST_DEEP_ENTRY: assert property (stb_rise && pend_q == 3'h3 |-> ##[1:8] power_state == 2'h2 && !reference_on)
      else $error("no deep power-down after fourth bare strobe");
   AST_WAKE: assert property (sck_rise |-> ##[1:6] power_state == 2'h0)
      else $error("clock edge did not wake the device");

   cover property (stb_rise && rise_q >= 5'h11);
   cover property (power_state == 2'h1);
   cover property (power_state == 2'h2 ##[1:20] power_state == 2'h0);
endmodule

// ===== bench/tb.sv
/*
 Testbench: both link ends joined, conversions, buffer stall, power-down and wake.
 Assumes the package, the link interface and both ends compiled before it.
*/
`timescale 1ns/10ps
module tb
   import sac_pkg::*;
;
   localparam int SKIP = 32'h7fffffff;
   logic              core_clk    = 1'b0;
   logic              nrst        = 1'b0;
   logic              convert_req = 1'b0;
   logic              nap_req     = 1'b0;
   logic              sleep_req   = 1'b0;
   logic              word_ready  = 1'b0;
   logic signed [13:0] p_in       = '0;
   logic signed [13:0] n_in       = '0;
   logic              busy;
   logic              word_valid;
   logic              ref_settled;
   logic              reference_on;
   logic [1:0]        power_state;
   logic [15:0]       word_data;
   logic [15:0]       sh          = '0;
   logic              sck_q       = 1'b0;
   int                nbits       = 0;
   int                miscompares = 0;
   int                checked     = 0;
   int                prev        = SKIP;
   int                expq[$];
   int                tp[6]       = '{100, -2000, 8191, -8192, 5000, -300};
   int                tn[6]       = '{-50, 1000, 0, 0, 5000, -300};

   always #5 core_clk = ~core_clk;

   sac_link_if sac_link_if_i ();
   sac_device #(.RES(RES_HIGH)) sac_device_i (.core_clk(core_clk), .nrst(nrst), .link(sac_link_if_i.device),
      .noninverting_analog_input(p_in), .inverting_analog_input(n_in), .power_state(power_state),
      .reference_on(reference_on));
   sac_ctrl #(.RES(RES_HIGH), .SETTLE(10)) sac_ctrl_i (.core_clk(core_clk), .nrst(nrst),
      .link(sac_link_if_i.ctrl), .convert_req(convert_req), .nap_req(nap_req), .sleep_req(sleep_req),
      .busy(busy), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
      .ref_settled(ref_settled));
   sac_properties #(.RES(RES_HIGH)) sac_properties_i (.core_clk(core_clk), .nrst(nrst),
      .shift_clk(sac_link_if_i.shift_clk), .conversion_start_strobe(sac_link_if_i.conversion_start_strobe),
      .serial_result_output(sac_link_if_i.serial_result_output),
      .serial_result_oe_n(sac_link_if_i.serial_result_oe_n), .power_state(power_state),
      .reference_on(reference_on));

   // Wire capture at each clock rise while driven
   always @(posedge core_clk)
   begin
      sck_q <= sac_link_if_i.shift_clk;
      if (sac_link_if_i.shift_clk && !sck_q && !sac_link_if_i.serial_result_oe_n)
      begin
         sh    <= {sh[14:0], sac_link_if_i.result_line};
         nbits <= nbits + 1;
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic convert(input int p, input int n);
      int i;
      int nb0;
      @(posedge core_clk);
      p_in        <= 14'(p);
      n_in        <= 14'(n);
      convert_req <= 1'b1;
      nb0 = nbits;
      for (i = 0; i < 200 && busy !== 1'b1; i++) @(negedge core_clk);
      @(posedge core_clk);
      convert_req <= 1'b0;
      for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
      chk("bit count", 16'(RES_HIGH), 16'(nbits - nb0));
      if (prev != SKIP) chk("wire bits", 16'(prev) & 16'h3fff, {2'h0, sh[13:0]});
      expq.push_back(prev);
      prev = p - n;
   endtask

   task automatic read_word();
      int          i;
      int          e;
      logic [15:0] got;
      @(negedge core_clk);
      for (i = 0; i < 400 && word_valid !== 1'b1; i++) @(negedge core_clk);
      got = word_data;
      chk("word_valid", 16'h1, {15'h0, word_valid});
      @(posedge core_clk);
      word_ready <= 1'b1;
      @(posedge core_clk);
      word_ready <= 1'b0;
      e = expq.pop_front();
      if (e != SKIP) chk("word", 16'(e), got);
   endtask

   task automatic power_down(input logic [1:0] st);
      int i;
      @(posedge core_clk);
      nap_req   <= (st == 2'h1);
      sleep_req <= (st == 2'h2);
      for (i = 0; i < 300 && power_state !== st; i++) @(negedge core_clk);
      repeat (4) @(negedge core_clk);
      chk("power", {14'h0, st}, {14'h0, power_state});
      chk("reference", {15'h0, st != 2'h2}, {15'h0, reference_on});
      chk("oe_n", 16'h1, {15'h0, sac_link_if_i.serial_result_oe_n});
      @(posedge core_clk);
      nap_req   <= 1'b0;
      sleep_req <= 1'b0;
      repeat (20) @(negedge core_clk);
   endtask

   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #300000;
      miscompares++;
      tally_and_finish();
   end

   initial
   begin
      int i;
      int k;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      @(negedge core_clk);
      chk("oe_n", 16'h1, {15'h0, sac_link_if_i.serial_result_oe_n});
      chk("power", 16'h0, {14'h0, power_state});
      $display("test reset done");
      convert(0, 0);
      read_word();
      for (k = 0; k < 6; k++)
      begin
         convert(tp[k], tn[k]);
         read_word();
      end
      $display("test conversions done");
      convert(11, 1);
      convert(-7, 20);
      @(posedge core_clk);
      convert_req <= 1'b1;
      repeat (100) @(negedge core_clk);
      chk("busy when full", 16'h0, {15'h0, busy});
      @(posedge core_clk);
      convert_req <= 1'b0;
      read_word();
      read_word();
      $display("test buffer stall done");
      power_down(2'h1);
      convert(-7, 20);
      read_word();
      chk("power", 16'h0, {14'h0, power_state});
      $display("test light power-down done");
      power_down(2'h2);
      convert(300, -300);
      read_word();
      for (i = 0; i < 100 && ref_settled !== 1'b1; i++) @(negedge core_clk);
      chk("ref_settled", 16'h1, {15'h0, ref_settled});
      chk("power", 16'h0, {14'h0, power_state});
      $display("test deep power-down done");
      tally_and_finish();
   end
endmodule
